// File: core/mbs_consts.svh
`ifndef MBS_CONSTS_SVH
`define MBS_CONSTS_SVH

// function codes served
`define FC_RD_COILS 8'h01
`define FC_RD_DISCRETE 8'h02
`define FC_RD_HOLDING 8'h03
`define FC_RD_INREGS 8'h04
`define FC_WR_COIL 8'h05
`define FC_WR_REG 8'h06
`define FC_WR_COILS 8'h0F
`define FC_WR_REGS 8'h10
`define FC_MASK_WR 8'h16
`define FC_RD_WR_REGS 8'h17

// exception codes
`define EXC_NONE 8'h00
`define EXC_FUNC 8'h01
`define EXC_ADDR 8'h02
`define EXC_VALUE 8'h03

// zero based region bases, in protocol address units
`define IN_BASE 18'h00000
`define OUT_BASE 18'h00400
`define COIL_BASE 18'h04000
// each region holds this many words, or sixteen times as many bits
`define REGION_WORDS 18'h00020
`define REGION_BITS 18'h00200
`define MEM_DEPTH 32

// quantity limits per request
`define MAX_RD_BITS 16'h07D0
`define MAX_RD_REGS 16'h007D
`define MAX_WR_BITS 16'h07B0
`define MAX_WR_REGS 16'h007B
`define MAX_RW_WR 16'h0079

// single coil values
`define COIL_ON 16'hFF00
`define COIL_OFF 16'h0000

// connection limit
`define MAX_CONN 3'h6

// status indicator timing
`define CLK_HZ 100000000
`define BLINK_MS 250
`define PAUSE_MS 2000
`define MS_TO_CYC(ms) ((ms) * (`CLK_HZ / 1000))

`endif

// File: core/mbs_pkg.sv
package mbs_pkg;

  // one decoded query from the protocol front end
  typedef struct packed {
    logic [7:0] func;
    logic [15:0] rd_addr;
    logic [15:0] rd_qty;
    logic [15:0] wr_addr;
    logic [15:0] wr_qty;
    logic [15:0] value;
    logic [15:0] or_mask;
  } req_t;

  // drive side write into the input region
  typedef struct packed {
    logic we;
    logic [4:0] addr;
    logic [15:0] data;
  } drv_wr_t;

  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} engine_state_t;

  typedef enum logic [1:0] {LED_PAUSE, LED_ON, LED_OFF} led_phase_t;

endpackage

// File: core/modbus_tcp_register_server.sv
`timescale 1ns/10ps
`default_nettype none
`include "mbs_consts.svh"

// Behaviour
// - protocol addresses are zero based
// - discrete inputs alias input register bits
// - input index/16 picks word, remainder bit
// - input region drive-written, network read-only
// - holding registers start at word 1024
// - coils start at 16384, bit 0 first
// - coils 16400-16415 are register 1025 bits
// - at most six concurrent connections
// - indicator blinks per connection, two-second pause
// - serve exactly functions 1-6, 15, 16, 22, 23
// - function 2 reads input bits from 0
// - function 4 reads input words from 0
// - buffered writes; function 23 reads before writing
// - unsupported function answers exception 01
// - address outside memory answers exception 02
// - illegal data value answers exception 03
module modbus_tcp_register_server import mbs_pkg::*; #(
  parameter int BLINK_CYC = `MS_TO_CYC(`BLINK_MS),
  parameter int PAUSE_CYC = `MS_TO_CYC(`PAUSE_MS)
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // query from the protocol front end
  input wire req_t req,
  input wire logic req_valid,
  output logic req_ready,
  // write data beats for functions 15, 16 and 23
  input wire logic [15:0] wr_data,
  input wire logic wr_valid,
  output logic wr_ready,
  // read data beats and completion
  output logic [15:0] rsp_data,
  output logic rsp_valid,
  output logic rsp_last,
  output logic done,
  output logic [7:0] exc_code,
  // drive side access
  input wire drv_wr_t drv_wr,
  input wire logic [4:0] drv_rd_addr,
  output logic [15:0] drv_rd_data,
  // connections and indicator
  input wire logic conn_open,
  input wire logic conn_close,
  output logic [2:0] conn_count,
  output logic conn_refused,
  output logic network_status_indicator
);

  logic [15:0] in_mem [0:`MEM_DEPTH-1];
  logic [15:0] out_mem [0:`MEM_DEPTH-1];
  engine_state_t state;
  logic [7:0] func;
  logic [8:0] rd_off;
  logic [15:0] rd_cnt;
  logic rd_bit;
  logic rd_out;
  logic [8:0] wr_off;
  logic [15:0] wr_cnt;
  logic wr_bit;
  logic [15:0] value;
  logic [15:0] or_mask;
  logic req_fire;
  logic [7:0] next_exc;
  logic next_rd_bit;
  logic next_rd_out;
  logic [8:0] next_rd_off;
  logic [8:0] next_wr_off;
  logic has_read;
  logic has_write;
  logic streamed;
  logic next_we;
  logic [15:0] next_wdata;
  logic [4:0] widx;
  logic [4:0] ridx;
  logic [15:0] rword;

  function automatic logic qty_ok(input logic [15:0] q, input logic [15:0] lim);
    qty_ok = (q != 16'h0000) && (q <= lim);
  endfunction

  // whole span must lie inside one region
  function automatic logic fits(input logic [15:0] a, input logic [15:0] q,
                                input logic [17:0] base, input logic [17:0] span);
    logic [17:0] endp;
    endp = {2'b00, a} + {2'b00, q};
    fits = ({2'b00, a} >= base) && (endp <= base + span);
  endfunction

  function automatic logic [8:0] rel(input logic [15:0] a, input logic [17:0] base);
    logic [17:0] d;
    d = {2'b00, a} - base;
    rel = d[8:0];
  endfunction

  assign req_fire = req_valid && req_ready;

  // query check: function first, then value, then address
  always_comb begin
    next_exc = `EXC_NONE;
    next_rd_bit = 1'b0;
    next_rd_out = 1'b0;
    has_read = 1'b0;
    has_write = 1'b0;
    next_rd_off = rel(req.rd_addr, `IN_BASE);
    next_wr_off = rel(req.wr_addr, `OUT_BASE);
    case (req.func)
      `FC_RD_COILS: begin
        has_read = 1'b1;
        next_rd_bit = 1'b1;
        next_rd_out = 1'b1;
        next_rd_off = rel(req.rd_addr, `COIL_BASE);
        if (!qty_ok(req.rd_qty, `MAX_RD_BITS)) next_exc = `EXC_VALUE;
        else if (!fits(req.rd_addr, req.rd_qty, `COIL_BASE, `REGION_BITS)) next_exc = `EXC_ADDR;
      end
      `FC_RD_DISCRETE: begin
        has_read = 1'b1;
        next_rd_bit = 1'b1;
        if (!qty_ok(req.rd_qty, `MAX_RD_BITS)) next_exc = `EXC_VALUE;
        else if (!fits(req.rd_addr, req.rd_qty, `IN_BASE, `REGION_BITS)) next_exc = `EXC_ADDR;
      end
      `FC_RD_HOLDING, `FC_RD_WR_REGS: begin
        has_read = 1'b1;
        has_write = (req.func == `FC_RD_WR_REGS);
        // either region, chosen by the start address
        next_rd_out = ({2'b00, req.rd_addr} >= `OUT_BASE);
        if (next_rd_out) next_rd_off = rel(req.rd_addr, `OUT_BASE);
        if (!qty_ok(req.rd_qty, `MAX_RD_REGS)) next_exc = `EXC_VALUE;
        else if (has_write && !qty_ok(req.wr_qty, `MAX_RW_WR)) next_exc = `EXC_VALUE;
        else if (!fits(req.rd_addr, req.rd_qty, next_rd_out ? `OUT_BASE : `IN_BASE,
                       `REGION_WORDS)) next_exc = `EXC_ADDR;
        else if (has_write && !fits(req.wr_addr, req.wr_qty, `OUT_BASE, `REGION_WORDS))
          next_exc = `EXC_ADDR;
      end
      `FC_RD_INREGS: begin
        has_read = 1'b1;
        if (!qty_ok(req.rd_qty, `MAX_RD_REGS)) next_exc = `EXC_VALUE;
        else if (!fits(req.rd_addr, req.rd_qty, `IN_BASE, `REGION_WORDS)) next_exc = `EXC_ADDR;
      end
      `FC_WR_COIL, `FC_WR_COILS: begin
        has_write = 1'b1;
        next_wr_off = rel(req.wr_addr, `COIL_BASE);
        if (req.func == `FC_WR_COIL && req.value != `COIL_ON && req.value != `COIL_OFF)
          next_exc = `EXC_VALUE;
        else if (req.func == `FC_WR_COILS && !qty_ok(req.wr_qty, `MAX_WR_BITS))
          next_exc = `EXC_VALUE;
        else if (!fits(req.wr_addr, req.func == `FC_WR_COIL ? 16'h0001 : req.wr_qty,
                       `COIL_BASE, `REGION_BITS)) next_exc = `EXC_ADDR;
      end
      `FC_WR_REG, `FC_MASK_WR: begin
        has_write = 1'b1;
        if (!fits(req.wr_addr, 16'h0001, `OUT_BASE, `REGION_WORDS)) next_exc = `EXC_ADDR;
      end
      `FC_WR_REGS: begin
        has_write = 1'b1;
        if (!qty_ok(req.wr_qty, `MAX_WR_REGS)) next_exc = `EXC_VALUE;
        else if (!fits(req.wr_addr, req.wr_qty, `OUT_BASE, `REGION_WORDS)) next_exc = `EXC_ADDR;
      end
      default: next_exc = `EXC_FUNC;
    endcase
  end

  // one word of the region per beat; bit functions pick bit off[3:0] of word off/16
  assign ridx = rd_bit ? rd_off[8:4] : rd_off[4:0];
  assign rword = rd_out ? out_mem[ridx] : in_mem[ridx];
  assign widx = wr_bit ? wr_off[8:4] : wr_off[4:0];
  assign streamed = (func == `FC_WR_COILS) || (func == `FC_WR_REGS) ||
                    (func == `FC_RD_WR_REGS);

  // write value for the addressed holding register
  always_comb begin
    next_wdata = out_mem[widx];
    next_we = 1'b0;
    if (state == ST_WRITE) begin
      next_we = !streamed || (wr_valid && wr_ready);
      case (func)
        `FC_WR_COIL: next_wdata[wr_off[3:0]] = (value == `COIL_ON);
        `FC_WR_COILS: next_wdata[wr_off[3:0]] = wr_data[0];
        `FC_WR_REG: next_wdata = value;
        `FC_MASK_WR: next_wdata = (out_mem[widx] & value) | (or_mask & ~value);
        default: next_wdata = wr_data;
      endcase
    end
  end

  // query engine; the read of function 23 runs before its write
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= ST_IDLE;
      req_ready <= 1'b1;
      wr_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_last <= 1'b0;
      rsp_data <= 16'h0000;
      done <= 1'b0;
      exc_code <= `EXC_NONE;
      func <= 8'h00;
      rd_off <= 9'h000;
      rd_cnt <= 16'h0000;
      rd_bit <= 1'b0;
      rd_out <= 1'b0;
      wr_off <= 9'h000;
      wr_cnt <= 16'h0000;
      wr_bit <= 1'b0;
      value <= 16'h0000;
      or_mask <= 16'h0000;
    end else begin
      done <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_last <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (req_fire) begin
            func <= req.func;
            rd_off <= next_rd_off;
            rd_cnt <= req.rd_qty;
            rd_bit <= next_rd_bit;
            rd_out <= next_rd_out;
            wr_off <= next_wr_off;
            wr_cnt <= req.wr_qty;
            wr_bit <= (req.func == `FC_WR_COIL) || (req.func == `FC_WR_COILS);
            value <= req.value;
            or_mask <= req.or_mask;
            if (next_exc != `EXC_NONE) begin
              // rejected query: answer only, no memory touched
              done <= 1'b1;
              exc_code <= next_exc;
            end else begin
              req_ready <= 1'b0;
              state <= has_read ? ST_READ : ST_WRITE;
              wr_ready <= !has_read && ((req.func == `FC_WR_COILS) ||
                                        (req.func == `FC_WR_REGS));
            end
          end
        end
        ST_READ: begin
          rsp_valid <= 1'b1;
          rsp_data <= rd_bit ? {15'h0000, rword[rd_off[3:0]]} : rword;
          rsp_last <= (rd_cnt == 16'h0001);
          rd_off <= rd_off + 9'h001;
          rd_cnt <= rd_cnt - 16'h0001;
          if (rd_cnt == 16'h0001) begin
            if (func == `FC_RD_WR_REGS) begin
              state <= ST_WRITE;
              wr_ready <= 1'b1;
            end else begin
              state <= ST_IDLE;
              req_ready <= 1'b1;
              done <= 1'b1;
              exc_code <= `EXC_NONE;
            end
          end
        end
        default: begin
          if (next_we) begin
            wr_off <= wr_off + 9'h001;
            wr_cnt <= wr_cnt - 16'h0001;
            if (!streamed || wr_cnt == 16'h0001) begin
              state <= ST_IDLE;
              wr_ready <= 1'b0;
              req_ready <= 1'b1;
              done <= 1'b1;
              exc_code <= `EXC_NONE;
            end
          end
        end
      endcase
    end
  end

  // holding region: written only by the engine, held until the engine overwrites it
  always_ff @(posedge clk_sys) begin
    if (next_we) out_mem[widx] <= next_wdata;
  end

  // input region: written only from the drive side
  always_ff @(posedge clk_sys) begin
    if (drv_wr.we) in_mem[drv_wr.addr] <= drv_wr.data;
  end

  // drive side view of the commands
  always_ff @(posedge clk_sys) begin
    if (rst) drv_rd_data <= 16'h0000;
    else drv_rd_data <= out_mem[drv_rd_addr];
  end

  // connection count, opens refused at the limit
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      conn_count <= 3'h0;
      conn_refused <= 1'b0;
    end else begin
      conn_refused <= conn_open && !conn_close && (conn_count == `MAX_CONN);
      if (conn_open && !conn_close && conn_count != `MAX_CONN)
        conn_count <= conn_count + 3'h1;
      else if (conn_close && !conn_open && conn_count != 3'h0)
        conn_count <= conn_count - 3'h1;
    end
  end

  led_phase_t led_phase;
  logic [27:0] led_timer;
  logic [2:0] blinks;

  // blink group: one flash per connection, then a long pause
  always_ff @(posedge clk_sys) begin
    if (rst || conn_count == 3'h0) begin
      led_phase <= LED_PAUSE;
      led_timer <= 28'h0000000;
      blinks <= 3'h0;
      network_status_indicator <= 1'b0;
    end else begin
      led_timer <= led_timer + 28'h0000001;
      case (led_phase)
        LED_PAUSE: begin
          if (led_timer >= 28'(PAUSE_CYC - 1)) begin
            led_phase <= LED_ON;
            led_timer <= 28'h0000000;
            blinks <= conn_count;
            network_status_indicator <= 1'b1;
          end
        end
        LED_ON: begin
          if (led_timer >= 28'(BLINK_CYC - 1)) begin
            led_phase <= LED_OFF;
            led_timer <= 28'h0000000;
            blinks <= blinks - 3'h1;
            network_status_indicator <= 1'b0;
          end
        end
        default: begin
          if (led_timer >= 28'(BLINK_CYC - 1)) begin
            led_timer <= 28'h0000000;
            led_phase <= (blinks == 3'h0) ? LED_PAUSE : LED_ON;
            network_status_indicator <= (blinks != 3'h0);
          end
        end
      endcase
    end
  end

  property p_unsupported;
    @(posedge clk_sys) disable iff (rst)
    req_fire && (req.func == 8'h07) |=> done && (exc_code == `EXC_FUNC) && req_ready;
  endproperty
  a_unsupported: assert property (p_unsupported) else $error("bad function not refused");

  property p_bad_addr;
    @(posedge clk_sys) disable iff (rst)
    req_fire && (req.func == `FC_RD_INREGS) && (req.rd_qty == 16'h0001) &&
      ({2'b00, req.rd_addr} >= `REGION_WORDS) |=> done && (exc_code == `EXC_ADDR);
  endproperty
  a_bad_addr: assert property (p_bad_addr) else $error("address not refused");

  property p_bad_value;
    @(posedge clk_sys) disable iff (rst)
    req_fire && (req.func == `FC_WR_COIL) && (req.value == 16'h1234)
      |=> done && (exc_code == `EXC_VALUE) && !rsp_valid;
  endproperty
  a_bad_value: assert property (p_bad_value) else $error("value not refused");

  property p_exc_silent;
    @(posedge clk_sys) disable iff (rst)
    done && (exc_code != `EXC_NONE) |-> !rsp_valid && (state == ST_IDLE) && !$past(next_we);
  endproperty
  a_exc_silent: assert property (p_exc_silent) else $error("exception with side effects");

  property p_rw_read_first;
    @(posedge clk_sys) disable iff (rst)
    req_fire && (req.func == `FC_RD_WR_REGS) && (next_exc == `EXC_NONE) && (req.rd_qty == 16'h0002)
      |=> (state == ST_READ) ##1 rsp_valid ##1 rsp_valid && rsp_last && (state == ST_WRITE);
  endproperty
  a_rw_read_first: assert property (p_rw_read_first) else $error("read not before write");

  property p_conn_limit;
    @(posedge clk_sys) disable iff (rst)
    (conn_count == `MAX_CONN) && conn_open && !conn_close |=> (conn_count == `MAX_CONN) && conn_refused;
  endproperty
  a_conn_limit: assert property (p_conn_limit) else $error("seventh connection taken");

  property p_conn_up;
    @(posedge clk_sys) disable iff (rst)
    conn_open && !conn_close && (conn_count < `MAX_CONN) |=> conn_count == $past(conn_count) + 3'h1;
  endproperty
  a_conn_up: assert property (p_conn_up) else $error("connection not counted");

  property p_led_dark;
    @(posedge clk_sys) disable iff (rst)
    (conn_count == 3'h0) |=> !network_status_indicator && (led_phase == LED_PAUSE);
  endproperty
  a_led_dark: assert property (p_led_dark) else $error("indicator lit with no connection");

  property p_bit_read;
    @(posedge clk_sys) disable iff (rst)
    (state == ST_READ) && rd_bit |=> rsp_valid && (rsp_data[15:1] == 15'h0000);
  endproperty
  a_bit_read: assert property (p_bit_read) else $error("bit read not one bit");

endmodule
`default_nettype wire

// File: tb/mbs_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// client side of the query bus, one query at a time
module mbs_host_model import mbs_pkg::*; (
  // clock
  input wire logic clk_sys,
  // query and write beats
  output req_t req,
  output logic req_valid,
  output logic [15:0] wr_data,
  output logic wr_valid,
  // answers
  input wire logic req_ready,
  input wire logic wr_ready,
  input wire logic [15:0] rsp_data,
  input wire logic rsp_valid,
  input wire logic rsp_last,
  input wire logic done,
  input wire logic [7:0] exc_code
);
  logic [15:0] rd[$];
  logic [7:0] exc;
  logic hung;
  // beat count at which the last-beat flag was seen, 0 if never
  int nlast;

  // idle lines at time zero
  initial begin
    req = '0;
    req_valid = 1'b0;
    wr_data = 16'h0000;
    wr_valid = 1'b0;
    hung = 1'b0;
  end

  // addresses go out zero based, as on the wire
  task automatic run(input req_t r, input logic [15:0] wq[$]);
    int n;
    int i;
    n = 0;
    i = 0;
    rd.delete();
    nlast = 0;
    @(posedge clk_sys);
    req <= r;
    req_valid <= 1'b1;
    @(posedge clk_sys);
    while (req_ready !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk_sys);
    end
    // released lines change, so a stale copy is never mistaken for data
    req <= ~r;
    req_valid <= 1'b0;
    wr_valid <= (wq.size() > 0);
    wr_data <= (wq.size() > 0) ? wq[0] : ~wr_data;
    n = 0;
    while (done !== 1'b1 && n < 400) begin
      @(posedge clk_sys);
      n++;
      if (rsp_valid === 1'b1) begin
        rd.push_back(rsp_data);
        if (rsp_last === 1'b1) nlast = rd.size();
      end
      if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
        i++;
        wr_data <= (i < wq.size()) ? wq[i] : ~wr_data;
        wr_valid <= (i < wq.size());
      end
    end
    exc = exc_code;
    hung = (done !== 1'b1);
  endtask
endmodule
`default_nettype wire

// File: tb/modbus_tcp_register_server_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "mbs_consts.svh"
module modbus_tcp_register_server_test import mbs_pkg::*; ;
  localparam int BLINK = 4;
  localparam int PAUSE = 20;
  logic clk_sys, rst, req_valid, req_ready, wr_valid, wr_ready, rsp_valid, rsp_last, done;
  logic conn_open, conn_close, conn_refused, network_status_indicator;
  req_t req;
  logic [15:0] wr_data, rsp_data, drv_rd_data, om;
  logic [15:0] bq[$];
  logic [7:0] exc_code;
  drv_wr_t drv_wr;
  logic [4:0] drv_rd_addr;
  logic [2:0] conn_count;
  // bit 15 of word 0 and bit 0 of word 1 are set, bit 14 of word 0 is clear
  logic [15:0] img [4] = '{16'h8F00, 16'h0003, 16'h0000, 16'hA5C3};
  int bad_count, compares;

  modbus_tcp_register_server #(.BLINK_CYC(BLINK), .PAUSE_CYC(PAUSE)) u_dut (
    .clk_sys(clk_sys), .rst(rst), .req(req), .req_valid(req_valid), .req_ready(req_ready),
    .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready), .rsp_data(rsp_data),
    .rsp_valid(rsp_valid), .rsp_last(rsp_last), .done(done), .exc_code(exc_code),
    .drv_wr(drv_wr), .drv_rd_addr(drv_rd_addr), .drv_rd_data(drv_rd_data),
    .conn_open(conn_open), .conn_close(conn_close), .conn_count(conn_count),
    .conn_refused(conn_refused), .network_status_indicator(network_status_indicator));

  mbs_host_model u_host (
    .clk_sys(clk_sys), .req(req), .req_valid(req_valid), .wr_data(wr_data),
    .wr_valid(wr_valid), .req_ready(req_ready), .wr_ready(wr_ready), .rsp_data(rsp_data),
    .rsp_valid(rsp_valid), .rsp_last(rsp_last), .done(done), .exc_code(exc_code));

  task automatic final_report();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // a wait that ran out ends the run at once
  task automatic hang(input string what);
    bad_count++;
    $display("wrong value %s expected completion seen timeout", what);
    final_report();
  endtask

  // one query, read and write fields share address and count
  task automatic q(input logic [7:0] f, input logic [15:0] a, input logic [15:0] n,
                   input logic [15:0] v, input logic [7:0] ex);
    u_host.run('{f, a, n, a, n, v, om}, bq);
    if (u_host.hung === 1'b1) hang("query done");
    check("exception", {8'h00, ex}, {8'h00, u_host.exc});
    bq.delete();
    om = 16'h0000;
  endtask

  task automatic dwr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    drv_wr <= '{1'b1, a, d};
    @(posedge clk_sys);
    drv_wr <= '{1'b0, ~a, ~d};
  endtask

  task automatic drd(input logic [4:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    drv_rd_addr <= a;
    repeat (2) @(posedge clk_sys);
    check("holding word", exp, drv_rd_data);
  endtask

  task automatic t_input();
    for (int k = 0; k < 4; k++) dwr(k[4:0], img[k]);
    q(`FC_RD_INREGS, 16'h0000, 16'h0004, 16'h0000, `EXC_NONE);
    for (int k = 0; k < 4; k++) check("input word", img[k], u_host.rd[k]);
    check("last beat", 16'h0004, 16'(u_host.nlast));
    q(`FC_RD_DISCRETE, 16'h000F, 16'h0002, 16'h0000, `EXC_NONE);
    check("bit 15", {15'h0, img[0][15]}, {15'h0, u_host.rd[0][0]});
    check("bit 16", {15'h0, img[1][0]}, {15'h0, u_host.rd[1][0]});
    q(`FC_RD_DISCRETE, 16'h0030, 16'h0010, 16'h0000, `EXC_NONE);
    for (int b = 0; b < 16; b++) check("bit 48+", {15'h0, img[3][b]}, {15'h0, u_host.rd[b][0]});
    q(`FC_RD_HOLDING, 16'h0003, 16'h0001, 16'h0000, `EXC_NONE);
    check("fn3 input", img[3], u_host.rd[0]);
    $display("test input region done");
  endtask

  task automatic t_output();
    q(`FC_WR_REG, 16'h0400, 16'h0001, 16'h1234, `EXC_NONE);
    drd(5'h00, 16'h1234);
    bq = {16'h0000, 16'hBEEF};
    q(`FC_WR_REGS, 16'h0401, 16'h0002, 16'h0000, `EXC_NONE);
    drd(5'h02, 16'hBEEF);
    q(`FC_WR_COIL, 16'h4010, 16'h0001, `COIL_ON, `EXC_NONE);
    q(`FC_WR_COIL, 16'h401F, 16'h0001, `COIL_ON, `EXC_NONE);
    drd(5'h01, 16'h8001);
    q(`FC_WR_COIL, 16'h4010, 16'h0001, `COIL_OFF, `EXC_NONE);
    bq = {16'h0001, 16'h0000, 16'h0001};
    q(`FC_WR_COILS, 16'h4000, 16'h0003, 16'h0000, `EXC_NONE);
    drd(5'h00, 16'h1235);
    q(`FC_RD_COILS, 16'h4000, 16'h0003, 16'h0000, `EXC_NONE);
    for (int b = 0; b < 3; b++) check("coil", {15'h0, ~b[0]}, {15'h0, u_host.rd[b][0]});
    om = 16'h0012;
    q(`FC_MASK_WR, 16'h0402, 16'h0001, 16'hFF00, `EXC_NONE);
    q(`FC_RD_HOLDING, 16'h0400, 16'h0003, 16'h0000, `EXC_NONE);
    check("fn3 w0", 16'h1235, u_host.rd[0]);
    check("fn3 w1", 16'h8000, u_host.rd[1]);
    check("fn22 w2", 16'hBE12, u_host.rd[2]);
    $display("test holding region done");
  endtask

  task automatic t_rdwr();
    bq = {16'h5A5A};
    u_host.run('{`FC_RD_WR_REGS, 16'h0400, 16'h0001, 16'h0400, 16'h0001, 16'h0000, 16'h0000}, bq);
    if (u_host.hung === 1'b1) hang("fn23 done");
    check("fn23 old", 16'h1235, u_host.rd[0]);
    drd(5'h00, 16'h5A5A);
    // two-word exchange: both old words come back before either is replaced
    bq = {16'h1111, 16'h2222};
    q(`FC_RD_WR_REGS, 16'h0401, 16'h0002, 16'h0000, `EXC_NONE);
    check("fn23 old w1", 16'h8000, u_host.rd[0]);
    check("fn23 old w2", 16'hBE12, u_host.rd[1]);
    check("fn23 last beat", 16'h0002, 16'(u_host.nlast));
    drd(5'h02, 16'h2222);
    bq.delete();
    $display("test read write done");
  endtask

  task automatic t_except();
    logic [7:0] fx [10] = '{8'h07, 8'h18, 8'h04, 8'h04, 8'h03, 8'h05, 8'h06, 8'h10, 8'h02, 8'h01};
    logic [15:0] ax [10] = '{16'h0000, 16'h0000, 16'h0020, 16'h001F, 16'h0000, 16'h4000,
                             16'h0000, 16'h0400, 16'h0200, 16'h4000};
    logic [15:0] nx [10] = '{16'h0001, 16'h0001, 16'h0001, 16'h0002, 16'h0000, 16'h0001,
                             16'h0001, 16'h007C, 16'h0001, 16'h07D1};
    logic [7:0] ex [10] = '{8'h01, 8'h01, 8'h02, 8'h02, 8'h03, 8'h03, 8'h02, 8'h03, 8'h02, 8'h03};
    for (int k = 0; k < 10; k++) begin
      q(fx[k], ax[k], nx[k], (fx[k] == 8'h05) ? 16'h1234 : 16'h0001, ex[k]);
      check("refused beats", 16'h0000, 16'(u_host.rd.size()));
    end
    drd(5'h00, 16'h5A5A);
    q(`FC_RD_INREGS, 16'h0000, 16'h0001, 16'h0000, `EXC_NONE);
    check("input word 0", img[0], u_host.rd[0]);
    $display("test exceptions done");
  endtask

  task automatic pulse(input logic o, input logic c, input logic [2:0] n, input logic rf);
    @(posedge clk_sys);
    conn_open <= o;
    conn_close <= c;
    @(posedge clk_sys);
    conn_open <= 1'b0;
    conn_close <= 1'b0;
    @(posedge clk_sys);
    check("refused", {15'h0, rf}, {15'h0, conn_refused});
    check("count", {13'h0, n}, {13'h0, conn_count});
  endtask

  // find the long dark gap, then count flashes over one group
  task automatic blinks(input int n);
    int lo;
    int t;
    int rises;
    logic prev;
    lo = 0;
    t = 0;
    rises = 0;
    prev = 1'b0;
    while (lo < 10 && t < 400) begin
      @(posedge clk_sys);
      t++;
      lo = (network_status_indicator === 1'b0) ? lo + 1 : 0;
    end
    if (t >= 400) hang("indicator pause");
    for (t = 0; t < 2 * BLINK * n + PAUSE; t++) begin
      @(posedge clk_sys);
      if (network_status_indicator === 1'b1 && prev === 1'b0) rises++;
      prev = network_status_indicator;
    end
    check("flashes", 16'(n), 16'(rises));
  endtask

  task automatic t_conn();
    for (int k = 0; k < 7; k++) pulse(1'b1, 1'b0, (k < 6) ? 3'(k + 1) : 3'h6, k == 6);
    pulse(1'b1, 1'b1, 3'h6, 1'b0);
    blinks(6);
    for (int k = 5; k > 0; k--) pulse(1'b0, 1'b1, 3'(k), 1'b0);
    blinks(1);
    pulse(1'b0, 1'b1, 3'h0, 1'b0);
    repeat (60) begin
      @(posedge clk_sys);
      check("dark", 16'h0000, {15'h0, network_status_indicator});
    end
    $display("test connections done");
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    rst = 1'b1;
    drv_wr = '0;
    drv_rd_addr = 5'h00;
    conn_open = 1'b0;
    conn_close = 1'b0;
    om = 16'h0000;
    bad_count = 0;
    compares = 0;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    t_input();
    t_output();
    t_rdwr();
    t_except();
    t_conn();
    final_report();
  end
endmodule
`default_nettype wire
